// ### design/mic_regs.vh
`ifndef MIC_REGS_VH
`define MIC_REGS_VH
// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define MIC_IDX_STATUS 3'h0
`define MIC_IDX_INTPRI 3'h1
`define MIC_IDX_CTRL   3'h2
`define MIC_IDX_FLAG   3'h3
`define MIC_IDX_NOCLR  3'h4
`define MIC_IDX_NMI    3'h5
// ----------------------------------------
// field positions
// ----------------------------------------
`define MIC_CTRL_RREN  7
`define MIC_CTRL_IVSEL 6
`define MIC_CTRL_HIEN  2
`define MIC_CTRL_MEDEN 1
`define MIC_CTRL_LOEN  0
`define MIC_STAT_NMIEX 7
`define MIC_NMI_FLAG0  4
// ----------------------------------------
// reset values
// ----------------------------------------
`define MIC_CTRL_RST   8'h00
`define MIC_INTPRI_RST 8'h00
`define MIC_NOCLR_RST  8'h00
`define MIC_NMIEN_RST  2'h0
// ----------------------------------------
// level codes and timing counts in cycles
// ----------------------------------------
`define MIC_LVL_OFF    2'h0
`define MIC_LVL_LO     2'h1
`define MIC_LVL_MED    2'h2
`define MIC_LVL_HI     2'h3
`define MIC_CYC_PUSH   9'h002
`define MIC_CYC_WAKE   9'h005
`define MIC_CYC_JUMP   9'h003
`define MIC_CYC_RET_S  9'h004
`define MIC_CYC_RET_L  9'h005
`define MIC_CYC_CCP    3'h4
`endif

// ### design/mic_pick.v
`timescale 1ns/100ps
// lowest index wins; with rotation the slot after last starts the search
module mic_pick (
  // requests
  input  wire [7:0] req,
  input  wire       rr_en,
  input  wire [2:0] last,
  // result
  output wire       any,
  output reg  [2:0] idx
);
  reg [2:0] start;
  reg [2:0] pos;
  integer   k;

  assign any = |req;

  // descending scan so the smallest distance from start is kept
  always @* begin
    start = rr_en ? last + 3'h1 : 3'h0;
    pos   = 3'h0;
    idx   = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      pos = start + k[2:0];
      if (req[pos]) begin
        idx = pos;
      end
    end
  end
endmodule

// ### design/mic_cnt.v
`timescale 1ns/100ps
// phase timer: holds a phase for exactly val cycles
module mic_cnt (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // control
  input  wire       load,
  input  wire [8:0] val,
  // status
  output wire       last_cyc
);
  reg [8:0] cnt_r;

  assign last_cyc = (cnt_r == 9'h001);

  // load wins over the running count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 9'h000;
    end else if (load) begin
      cnt_r <= val;
    end else if (cnt_r != 9'h000) begin
      cnt_r <= cnt_r - 9'h001;
    end
  end
endmodule

// ### design/mic_ctrl.v
`timescale 1ns/100ps
`include "mic_regs.vh"
module mic_ctrl #(
  parameter       PC_WIDE    = 1,
  parameter [8:0] WAKE_START = 9'h010
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // peripheral side
  input  wire [7:0]  src_cond,
  input  wire [15:0] src_lvl,
  input  wire [7:0]  src_flag_clr,
  input  wire [1:0]  nmi_cond,
  // core side inputs
  input  wire        core_gie,
  input  wire        instr_done,
  input  wire        irq_return_instr,
  input  wire        core_asleep,
  input  wire        lock_block,
  input  wire        ccp_unlock,
  // core side outputs
  output reg         irq_take,
  output wire        core_hold,
  output wire        push_pc,
  output wire        pc_load,
  output wire        pop_pc,
  output reg         vec_nmi,
  output reg  [2:0]  vec_idx,
  output reg  [1:0]  vec_lvl,
  output wire        ivsel,
  output wire [3:0]  exec_lvl
);
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  localparam [2:0] S_RUN  = 3'h0;
  localparam [2:0] S_PUSH = 3'h1;
  localparam [2:0] S_VEC  = 3'h2;
  localparam [2:0] S_JMP  = 3'h3;
  localparam [2:0] S_RET  = 3'h4;

  reg  [2:0] st_r, st_nxt, ccp_r, gl;
  reg  [7:0] ctrl_r, intpri_r, flag_r, noclr_r;
  reg  [1:0] nmi_en_r, nmi_flag_r;
  reg  [3:0] ex_r;
  reg        need_r, cnt_load;
  reg  [8:0] cnt_val;
  wire       cnt_last, lo_any, med_any, hi_any, blk, mask_ok, go, vec_sel_nmi;
  wire [7:0] lo_req, med_req, hi_req, ack_clr;
  wire [2:0] lo_idx, med_idx, hi_idx, cur, take_idx;
  wire [1:0] nmi_req;
  wire [3:0] top;

  // ----------------------------------------
  // apb access
  // ----------------------------------------
  wire       setup  = psel & ~penable;
  wire       wr     = psel & penable & pwrite;
  wire       hit    = (paddr[7:5] == 3'h0) & (paddr[4:2] <= `MIC_IDX_NMI);
  wire [2:0] ridx   = paddr[4:2];
  wire       wr_pri = wr & hit & (ridx == `MIC_IDX_INTPRI);
  wire       wr_flg = wr & hit & (ridx == `MIC_IDX_FLAG);
  wire       wr_nmi = wr & hit & (ridx == `MIC_IDX_NMI);

  // zero wait states: read data is captured in the setup cycle, write data in the access cycle
  assign pready = 1'b1;

  // read data and error latched during setup, stable in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~hit;
      case (hit ? ridx : 3'h7) // unmapped falls to the default
        `MIC_IDX_STATUS: prdata <= {24'h0, ex_r[3], 4'h0, ex_r[2:0]};
        `MIC_IDX_INTPRI: prdata <= {24'h0, intpri_r};
        `MIC_IDX_CTRL:   prdata <= {24'h0, ctrl_r};
        `MIC_IDX_FLAG:   prdata <= {24'h0, flag_r};
        `MIC_IDX_NOCLR:  prdata <= {24'h0, noclr_r};
        `MIC_IDX_NMI:    prdata <= {26'h0, nmi_flag_r, 2'h0, nmi_en_r};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // plain configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `MIC_CTRL_RST;
      noclr_r  <= `MIC_NOCLR_RST;
      nmi_en_r <= `MIC_NMIEN_RST;
    end else if (wr && hit) begin
      if (ridx == `MIC_IDX_CTRL) begin
        ctrl_r <= pwdata[7:0] & 8'hC7; // reserved bits stay zero
      end
      if (ridx == `MIC_IDX_NOCLR) begin
        noclr_r <= pwdata[7:0];
      end
      if (ridx == `MIC_IDX_NMI) begin
        nmi_en_r <= pwdata[1:0];
      end
    end
  end

  assign ivsel = ctrl_r[`MIC_CTRL_IVSEL];

  // ----------------------------------------
  // source flags and level qualification
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_src
      wire [1:0] lv  = src_lvl[2*i+1:2*i];
      wire       clr = (wr_flg & pwdata[i]) | src_flag_clr[i] | ack_clr[i];
      // set wins over any clear in the same cycle
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_r[i] <= 1'b0;
        end else begin
          flag_r[i] <= src_cond[i] | (flag_r[i] & ~clr);
        end
      end
      // code 00 keeps the source out of every level
      assign lo_req[i]  = flag_r[i] & (lv == `MIC_LVL_LO)  & ctrl_r[`MIC_CTRL_LOEN];
      assign med_req[i] = flag_r[i] & (lv == `MIC_LVL_MED) & ctrl_r[`MIC_CTRL_MEDEN];
      assign hi_req[i]  = flag_r[i] & (lv == `MIC_LVL_HI)  & ctrl_r[`MIC_CTRL_HIEN];
      // vector execution clears the flag unless the source keeps it
      assign ack_clr[i] = go & (gl != 3'h4) & (take_idx == i) & ~noclr_r[i];
    end
  endgenerate

  // nmi flags: set wins, cleared by their own vector or write-one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_flag_r <= 2'h0;
    end else begin
      nmi_flag_r <= nmi_cond | (nmi_flag_r & ~((go && gl == 3'h4) ? (2'h1 << vec_sel_nmi) : 2'h0)
                    & ~(wr_nmi ? pwdata[`MIC_NMI_FLAG0+1:`MIC_NMI_FLAG0] : 2'h0));
    end
  end

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  // low level may rotate; medium and high are always static
  mic_pick u_lo (
    .req   (lo_req),
    .rr_en (ctrl_r[`MIC_CTRL_RREN]),
    .last  (intpri_r[2:0]),
    .any   (lo_any),
    .idx   (lo_idx)
  );

  mic_pick u_med (.req(med_req), .rr_en(1'b0), .last(3'h0), .any(med_any), .idx(med_idx));
  mic_pick u_hi  (.req(hi_req), .rr_en(1'b0), .last(3'h0), .any(hi_any), .idx(hi_idx));

  assign nmi_req = nmi_flag_r & nmi_en_r;
  assign vec_sel_nmi = ~nmi_req[0];

  // rank of the running handler: 0 none .. 4 nmi
  assign cur = ex_r[3] ? 3'h4 : ex_r[2] ? 3'h3 : ex_r[1] ? 3'h2 : ex_r[0] ? 3'h1 : 3'h0;

  // unlock window plus the signature cycle itself
  assign blk     = lock_block | ccp_unlock | (ccp_r != 3'h0);
  assign mask_ok = core_gie & ~blk;

  // granted rank, recomputed from live flags every cycle
  always @* begin
    gl = 3'h0;
    if (|nmi_req && !blk && cur < 3'h4) begin
      gl = 3'h4;
    end else if (mask_ok && hi_any && cur < 3'h3) begin
      gl = 3'h3;
    end else if (mask_ok && med_any && cur < 3'h2) begin
      gl = 3'h2;
    end else if (mask_ok && lo_any && cur < 3'h1) begin
      gl = 3'h1;
    end
  end

  assign take_idx = (gl == 3'h4) ? {2'h0, vec_sel_nmi} :
                    (gl == 3'h3) ? hi_idx : (gl == 3'h2) ? med_idx : lo_idx;

  // boundary only: the core flags instruction completion
  assign go = (st_r == S_RUN) & instr_done & ~need_r & ~irq_return_instr & (gl != 3'h0);

  // ----------------------------------------
  // unlock suppression counter
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccp_r <= 3'h0;
    end else if (ccp_unlock) begin
      ccp_r <= `MIC_CYC_CCP - 3'h1;
    end else if (ccp_r != 3'h0) begin
      ccp_r <= ccp_r - 3'h1;
    end
  end

  // ----------------------------------------
  // round-robin memory
  // ----------------------------------------
  // hardware update wins over a software write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intpri_r <= `MIC_INTPRI_RST;
    end else if (go && gl == 3'h1 && ctrl_r[`MIC_CTRL_RREN]) begin
      intpri_r <= {5'h00, lo_idx};
    end else if (wr_pri) begin
      intpri_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // executing-level state
  // ----------------------------------------
  // return clears only the top bit, so the state before entry comes back
  assign top      = ex_r[3] ? 4'h8 : ex_r[2] ? 4'h4 : ex_r[1] ? 4'h2 : ex_r[0] ? 4'h1 : 4'h0;
  assign exec_lvl = ex_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_r <= 4'h0;
    end else if (go) begin
      ex_r <= ex_r | (4'h1 << (gl - 3'h1));
    end else if (st_r == S_RET && cnt_last) begin
      ex_r <= ex_r & ~top;
    end
  end

  // ----------------------------------------
  // response and return sequencer
  // ----------------------------------------
  // the status word is left to software: nothing here stacks it
  // handlers must use the interrupt return or levels stay set
  always @* begin
    st_nxt   = st_r;
    cnt_load = 1'b0;
    cnt_val  = `MIC_CYC_PUSH;
    case (st_r)
      S_RUN: begin
        if (irq_return_instr) begin
          st_nxt   = S_RET;
          cnt_load = 1'b1;
          cnt_val  = PC_WIDE ? `MIC_CYC_RET_L : `MIC_CYC_RET_S;
        end else if (go) begin
          st_nxt   = S_PUSH;
          cnt_load = 1'b1;
          // waking costs extra cycles plus the sleep start-up
          cnt_val  = core_asleep ? `MIC_CYC_PUSH + `MIC_CYC_WAKE + WAKE_START
                                 : `MIC_CYC_PUSH;
        end
      end
      S_PUSH: begin
        if (cnt_last) begin
          st_nxt = S_VEC;
        end
      end
      S_VEC: begin
        st_nxt   = S_JMP;
        cnt_load = 1'b1;
        cnt_val  = `MIC_CYC_JUMP;
      end
      S_JMP, S_RET: begin
        if (cnt_last) begin
          st_nxt = S_RUN;
        end
      end
      default: begin
        st_nxt = S_RUN;
      end
    endcase
  end

  mic_cnt u_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (cnt_load),
    .val      (cnt_val),
    .last_cyc (cnt_last)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // one instruction must retire after any entry or return
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      need_r <= 1'b0;
    end else if ((st_r == S_JMP || st_r == S_RET) && cnt_last) begin
      need_r <= 1'b1;
    end else if (st_r == S_RUN && instr_done) begin
      need_r <= 1'b0;
    end
  end

  // granted vector, held until the next grant
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_take <= 1'b0;
      vec_nmi  <= 1'b0;
      vec_idx  <= 3'h0;
      vec_lvl  <= `MIC_LVL_OFF;
    end else begin
      irq_take <= go;
      if (go) begin
        vec_nmi <= (gl == 3'h4);
        vec_idx <= take_idx;
        vec_lvl <= (gl == 3'h4) ? `MIC_LVL_HI : gl[1:0];
      end
    end
  end

  // core strobes; the global enable is never driven from here
  assign core_hold = (st_r != S_RUN);
  assign push_pc   = (st_r == S_PUSH);
  assign pc_load   = (st_r == S_VEC);
  assign pop_pc    = (st_r == S_RET);
endmodule

// ### tb/mic_ctrl_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// entry, return and masking checks
// ----------------------------------------
module mic_ctrl_chk #(
  parameter PC_WIDE = 1
) (
  // clock and reset
  input wire       pclk,
  input wire       presetn,
  // core side inputs
  input wire       core_gie,
  input wire       instr_done,
  input wire       core_asleep,
  input wire       lock_block,
  input wire       ccp_unlock,
  // core side outputs
  input wire       irq_take,
  input wire       core_hold,
  input wire       push_pc,
  input wire       pc_load,
  input wire       pop_pc,
  input wire       vec_nmi,
  input wire [1:0] vec_lvl,
  input wire [3:0] exec_lvl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a return unwinds only the highest executing level
  function automatic [3:0] top_clr(input [3:0] x);
    top_clr = x[3] ? {1'b0, x[2:0]} : x[2] ? {2'b00, x[1:0]} : x[1] ? {3'b000, x[0]} : 4'h0;
  endfunction
  chk_resp_time: assert property (irq_take && !$past(core_asleep) |->
    push_pc ##1 push_pc ##1 (pc_load && !push_pc)) else $error("push phase length wrong");
  chk_jump_len: assert property (pc_load |=> core_hold [*3] ##1 !core_hold)
    else $error("jump phase length wrong");
  chk_ret_five: assert property (PC_WIDE == 1 && $rose(pop_pc) |-> pop_pc [*5] ##1 !pop_pc)
    else $error("long return length wrong");
  chk_ret_four: assert property (PC_WIDE != 1 && $rose(pop_pc) |-> pop_pc [*4] ##1 !pop_pc)
    else $error("short return length wrong");
  chk_ret_unwind: assert property ($fell(pop_pc) |-> exec_lvl == top_clr($past(exec_lvl)))
    else $error("return left wrong level state");
  chk_gie_mask: assert property (irq_take && !vec_nmi |-> $past(core_gie))
    else $error("maskable taken with global enable off");
  chk_lock_block: assert property (irq_take |-> !$past(lock_block))
    else $error("taken while locked section runs");
  chk_ccp_quiet: assert property (irq_take |-> !($past(ccp_unlock) || $past(ccp_unlock, 2) ||
    $past(ccp_unlock, 3) || $past(ccp_unlock, 4))) else $error("taken inside unlock window");
  chk_nmi_solo: assert property (irq_take |-> !$past(exec_lvl[3]))
    else $error("nmi handler preempted");
  chk_level_rank: assert property (irq_take |-> vec_nmi || (vec_lvl != 2'h0 &&
    ($past(exec_lvl) >> (vec_lvl - 2'h1)) == 4'h0)) else $error("grant not above running level");
  chk_instr_first: assert property (irq_take |-> $past(instr_done))
    else $error("entry without a retired instruction");
  // main scenarios seen
  cover property (irq_take && vec_nmi);
  cover property (irq_take && vec_lvl == 2'h2 && $past(exec_lvl[0]));
  cover property ($fell(pop_pc) && exec_lvl != 4'h0);
endmodule

bind mic_ctrl mic_ctrl_chk #(.PC_WIDE(PC_WIDE)) u_chk (.pclk(pclk), .presetn(presetn), .core_gie(core_gie),
  .instr_done(instr_done), .core_asleep(core_asleep), .lock_block(lock_block), .ccp_unlock(ccp_unlock),
  .irq_take(irq_take), .core_hold(core_hold), .push_pc(push_pc), .pc_load(pc_load), .pop_pc(pop_pc),
  .vec_nmi(vec_nmi), .vec_lvl(vec_lvl), .exec_lvl(exec_lvl));

// ### tb/mic_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// core model: retires instructions, issues returns
// ----------------------------------------
module mic_core_model (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // bench control
  input  wire slow,
  input  wire ret_req,
  // controller side
  input  wire core_hold,
  output wire instr_done,
  output wire irq_return_instr
);
  reg [1:0] cnt_r;
  reg       ret_pend_r;
  // slow mode models a three-cycle instruction; a stalled core does not advance
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      ret_pend_r <= 1'b0;
    end else begin
      if (!core_hold) cnt_r <= (cnt_r == 2'h0) ? (slow ? 2'h2 : 2'h0) : cnt_r - 2'h1;
      ret_pend_r <= ret_req | (ret_pend_r & ~irq_return_instr);
    end
  end
  // gated by hold so a return requested mid-entry is not lost
  assign instr_done = presetn & (cnt_r == 2'h0) & ~core_hold & ~ret_pend_r;
  assign irq_return_instr = ret_pend_r & ~core_hold;
endmodule

// ### tb/tb_mic_ctrl.sv
`timescale 1ns/100ps
module tb_mic_ctrl;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  reg         pclk, presetn, psel, penable, pwrite, core_gie, slow, ret_req;
  reg  [7:0]  paddr, src_cond;
  reg  [31:0] pwdata, d;
  reg  [15:0] src_lvl;
  reg  [1:0]  nmi_cond;
  reg         e;
  reg         core_asleep, lock_block, ccp_unlock;
  reg  [7:0]  src_flag_clr;
  wire [31:0] prdata;
  wire        pready, pslverr, instr_done, irq_return_instr, irq_take, core_hold, push_pc, pc_load, pop_pc;
  wire        vec_nmi, ivsel;
  wire [2:0]  vec_idx;
  wire [1:0]  vec_lvl;
  wire [3:0]  exec_lvl;
  integer     n_mismatch, checked, n_take, i, n_push, p0;
  always #4 pclk = ~pclk;
  // count grants so a wait cannot miss a one-cycle pulse
  always @(posedge pclk) if (irq_take === 1'b1) n_take <= n_take + 1;
  // push cycles, to measure the wake-up entry
  always @(posedge pclk) if (push_pc === 1'b1) n_push <= n_push + 1;
  mic_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_cond(src_cond), .src_lvl(src_lvl),
    .src_flag_clr(src_flag_clr), .nmi_cond(nmi_cond), .core_gie(core_gie), .instr_done(instr_done),
    .irq_return_instr(irq_return_instr), .core_asleep(core_asleep), .lock_block(lock_block),
    .ccp_unlock(ccp_unlock),
    .irq_take(irq_take), .core_hold(core_hold), .push_pc(push_pc), .pc_load(pc_load), .pop_pc(pop_pc),
    .vec_nmi(vec_nmi), .vec_idx(vec_idx), .vec_lvl(vec_lvl), .ivsel(ivsel), .exec_lvl(exec_lvl));
  mic_core_model u_core (.pclk(pclk), .presetn(presetn), .slow(slow), .ret_req(ret_req), .core_hold(core_hold),
    .instr_done(instr_done), .irq_return_instr(irq_return_instr));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task end_of_test;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task tmo;
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] x);
    begin
      checked = checked + 1;
      if (s !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input w, input [7:0] a, input [31:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
        @(posedge pclk);
        i = i + 1;
      end while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1) tmo;
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] x, input string nm);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, d, x);
    end
  endtask
  task cond(input [7:0] c, input [1:0] n);
    begin
      @(posedge pclk);
      src_cond <= c;
      nmi_cond <= n;
      @(posedge pclk);
      src_cond <= 8'h00;
      nmi_cond <= 2'h0;
    end
  endtask
  task quiet(input integer k, input string s);
    begin
      repeat (20) @(posedge pclk);
      #1;
      chk(s, n_take, k);
    end
  endtask
  // wait for grant number k, then compare the granted vector
  task serve(input integer k, input [1:0] l, input [2:0] x, input nm, input string s);
    begin
      i = 0;
      while (n_take < k && i < 300) begin
        @(posedge pclk);
        #1;
        i = i + 1;
      end
      if (n_take < k) tmo;
      chk(s, {vec_nmi, vec_lvl, vec_idx}, {nm, l, x});
    end
  endtask
  // return count is fixed, 16 cycles covers a stalled request too
  task ret;
    begin
      @(posedge pclk);
      ret_req <= 1'b1;
      @(posedge pclk);
      ret_req <= 1'b0;
      repeat (16) @(posedge pclk);
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; src_cond = 0;
    src_lvl = 0; nmi_cond = 0; core_gie = 0; slow = 0; ret_req = 0; n_mismatch = 0; checked = 0; n_take = 0;
    core_asleep = 0;
    lock_block = 0;
    ccp_unlock = 0;
    src_flag_clr = 0;
    n_push = 0;
    p0 = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 32'h0, "ctrl reset");
    rd(8'h04, 32'h0, "intpri reset");
    rd(8'h10, 32'h0, "noclr reset");
    rd(8'h00, 32'h0, "status reset");
    rd(8'h20, 32'h0, "unmapped data");
    chk("unmapped err", e, 1);
    apb(1'b1, 8'h08, 32'hFF);
    rd(8'h08, 32'hC7, "ctrl reserved");
    chk("ivsel on", ivsel, 1);
    apb(1'b1, 8'h08, 32'h00);
    #1;
    chk("ivsel off", ivsel, 0);
    cond(8'h08, 2'h0);
    rd(8'h0C, 32'h08, "flag disabled");
    apb(1'b1, 8'h0C, 32'h08);
    rd(8'h0C, 32'h0, "flag w1c");
    cond(8'h40, 2'h0);
    @(posedge pclk);
    src_flag_clr <= 8'h40;
    @(posedge pclk);
    src_flag_clr <= 8'h00;
    rd(8'h0C, 32'h0, "access clear");
    src_lvl <= 16'h0412;
    core_gie <= 1'b1;
    cond(8'h24, 2'h0);
    quiet(0, "level off");
    core_gie <= 1'b0;
    apb(1'b1, 8'h08, 32'h03);
    quiet(0, "gie off");
    core_gie <= 1'b1;
    serve(1, 2'h1, 3'h2, 1'b0, "lo lowest");
    rd(8'h0C, 32'h20, "vector clear");
    quiet(1, "same level");
    cond(8'h01, 2'h0);
    serve(2, 2'h2, 3'h0, 1'b0, "med preempt");
    rd(8'h00, 32'h03, "nested");
    ret;
    rd(8'h00, 32'h01, "unwind");
    ret;
    serve(3, 2'h1, 3'h5, 1'b0, "lo pending");
    ret;
    rd(8'h00, 32'h0, "idle");
    core_gie <= 1'b0;
    slow <= 1'b1;
    apb(1'b1, 8'h14, 32'h03);
    cond(8'h00, 2'h3);
    serve(4, 2'h3, 3'h0, 1'b1, "nmi first");
    rd(8'h14, 32'h23, "nmi lowest");
    rd(8'h00, 32'h80, "nmi exec");
    ret;
    serve(5, 2'h3, 3'h1, 1'b1, "nmi second");
    ret;
    rd(8'h14, 32'h03, "nmi done");
    core_gie <= 1'b1;
    slow <= 1'b0;
    apb(1'b1, 8'h04, 32'h02);
    apb(1'b1, 8'h08, 32'h81);
    cond(8'h24, 2'h0);
    serve(6, 2'h1, 3'h5, 1'b0, "rr rotate");
    ret;
    serve(7, 2'h1, 3'h2, 1'b0, "rr wrap");
    rd(8'h04, 32'h02, "rr last");
    ret;
    // locked section, then unlock window, entry from sleep, kept flag
    apb(1'b1, 8'h10, 32'h20);
    lock_block <= 1'b1;
    core_asleep <= 1'b1;
    cond(8'h24, 2'h0);
    quiet(7, "locked");
    p0 = n_push;
    @(posedge pclk);
    lock_block <= 1'b0;
    ccp_unlock <= 1'b1;
    @(posedge pclk);
    ccp_unlock <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk("unlock quiet", n_take, 7);
    serve(8, 2'h1, 3'h5, 1'b0, "after unlock");
    core_asleep <= 1'b0;
    repeat (30) @(posedge pclk);
    chk("wake push", n_push - p0, 23);
    rd(8'h0C, 32'h24, "noclr kept");
    apb(1'b1, 8'h0C, 32'h20);
    ret;
    serve(9, 2'h1, 3'h2, 1'b0, "rr after");
    ret;
    end_of_test;
  end
endmodule
